//--- hdl/uecs_top.sv
/*
 * Per-endpoint stall, buffer-full and packet size logic, endpoint 0 control phase.
 * Assumes the protocol engine reports tokens and buffer events synchronous
 * to ref_clk, one of each per cycle, and an AHB-Lite master with one slave.
 */
`default_nettype none
module uecs_top #(
    parameter int NUM_EP = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic usb_bus_reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire uecs_pkg::uecs_tok_s tok,
    input wire uecs_pkg::uecs_ev_s ev,
    input wire logic [2*NUM_EP:0] dbl_buf,
    output uecs_pkg::uecs_resp_s resp,
    output uecs_pkg::uecs_cnt_s cnt_load,
    output uecs_pkg::uecs_clr_s rx_clear
);
    import uecs_pkg::*;

    localparam int NSETS = 2 * NUM_EP + 1;
    localparam int SW = $clog2(NSETS);
    localparam logic [SW-1:0] SETUP_IDX = SW'(NSETS - 1);

    // Setup set is last; others are endpoint*2 + direction
    function automatic logic [SW-1:0] set_of(uecs_sel_s s);
        set_of = s.setup ? SETUP_IDX : SW'(2 * int'(s.ep) + int'(s.dir));
    endfunction

    function automatic logic [1:0] cap_of(logic dbl);
        cap_of = dbl ? 2'h2 : 2'h1;
    endfunction

    logic ph_valid_r, ph_valid_nxt;
    logic ph_write_r, ph_write_nxt;
    logic [31:0] ph_addr_r, ph_addr_nxt;
    uecs_sel_s idx_r, idx_nxt;
    logic [NSETS-1:0] stall_r, stall_nxt;
    logic [SZ_W-1:0] size_r [NSETS];
    logic [SZ_W-1:0] size_nxt [NSETS];
    logic [NT_W-1:0] nt_r [NSETS];
    logic [NT_W-1:0] nt_nxt [NSETS];
    logic stat_r, stat_nxt;
    logic data_r, data_nxt;
    logic [1:0] cnt_r [NSETS];
    logic [1:0] cnt_nxt [NSETS];
    uecs_resp_s resp_r, resp_nxt;
    uecs_cnt_s load_r, load_nxt;
    uecs_clr_s clr_r, clr_nxt;
    logic [SW-1:0] cur;
    logic cur_ep0;
    logic cur_full;
    logic wr_ctl, wr_sz, wr_eix;
    logic ev_ep0;
    logic [SW-1:0] ev_set;

    assign cur = set_of(idx_r);
    assign cur_ep0 = idx_r.setup || (idx_r.ep == 4'h0);
    assign wr_ctl = ph_valid_r && ph_write_r && (ph_addr_r == ADDR_ECTRL);
    assign wr_sz = ph_valid_r && ph_write_r && (ph_addr_r == ADDR_MAXSIZE);
    assign wr_eix = ph_valid_r && ph_write_r && (ph_addr_r == ADDR_EIX);
    assign ev_set = set_of(ev.sel);
    assign ev_ep0 = !ev.sel.setup && (ev.sel.ep == 4'h0);

    // IN sets need every buffer full, OUT sets any
    assign cur_full = (idx_r.dir && !idx_r.setup)
        ? (cnt_r[cur] == cap_of(dbl_buf[cur]))
        : (cnt_r[cur] != 2'h0);

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign resp = resp_r;
    assign cnt_load = load_r;
    assign rx_clear = clr_r;

    always_comb
    begin
        ph_valid_nxt = ph_valid_r;
        ph_write_nxt = ph_write_r;
        ph_addr_nxt = ph_addr_r;
        if (hready)
        begin
            ph_valid_nxt = hsel && (htrans == HTRANS_NONSEQ);
            ph_write_nxt = hwrite;
            ph_addr_nxt = haddr;
        end
    end

    always_comb
    begin
        hrdata = 32'h0000_0000;
        if (ph_valid_r && !ph_write_r)
        begin
            unique case (ph_addr_r)
                ADDR_ECTRL:
                begin
                    hrdata[CTL_STALL] = stall_r[cur];
                    hrdata[CTL_STATUS] = cur_ep0 && stat_r;
                    hrdata[CTL_DATA] = cur_ep0 && data_r;
                    hrdata[CTL_FULL] = cur_full;
                end
                ADDR_MAXSIZE:
                begin
                    hrdata[SZ_LSB +: SZ_W] = size_r[cur];
                    hrdata[NT_LSB +: NT_W] = nt_r[cur];
                end
                ADDR_EIX:
                    hrdata[EIX_W-1:0] = idx_r;
                default:
                    hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Index, stall, size and control phase state
    always_comb
    begin
        idx_nxt = idx_r;
        stall_nxt = stall_r;
        size_nxt = size_r;
        nt_nxt = nt_r;
        stat_nxt = stat_r;
        data_nxt = data_r;
        if (wr_eix)
            idx_nxt = hwdata[EIX_W-1:0];
        if (wr_ctl)
        begin
            stall_nxt[cur] = hwdata[CTL_STALL];
            if (cur_ep0 && hwdata[CTL_STATUS])
                stat_nxt = 1'b1;
            if (cur_ep0 && hwdata[CTL_DATA])
                data_nxt = 1'b1;
        end
        if (wr_sz)
        begin
            size_nxt[cur] = hwdata[SZ_LSB +: SZ_W];
            nt_nxt[cur] = hwdata[NT_LSB +: NT_W];
        end
        // Status phase ends when its handshake completes
        if (stat_r && ev.valid && ev_ep0
            && ((ev.kind == EV_TX_ACKED && ev.sel.dir)
            || (ev.kind == EV_RX_ACKED && !ev.sel.dir)))
        begin
            stat_nxt = 1'b0;
            data_nxt = 1'b0;
        end
        // A new SETUP aborts any phase, even one written this cycle
        if (tok.valid && tok.pid == PID_SETUP && tok.ep == 4'h0)
        begin
            stat_nxt = 1'b0;
            data_nxt = 1'b0;
        end
        if (usb_bus_reset)
        begin
            idx_nxt = '0;
            stall_nxt = '0;
            size_nxt = '{default: '0};
            nt_nxt = '{default: '0};
            stat_nxt = 1'b0;
            data_nxt = 1'b0;
        end
    end

    // Buffer fill counts and buffer clear pulses
    always_comb
    begin
        cnt_nxt = cnt_r;
        clr_nxt = '0;
        if (ev.valid)
        begin
            unique case (ev.kind)
                EV_TX_VALID, EV_RX_ACKED:
                    if (cnt_r[ev_set] != cap_of(dbl_buf[ev_set]))
                        cnt_nxt[ev_set] = cnt_r[ev_set] + 2'h1;
                EV_TX_ACKED:
                    if (cnt_r[ev_set] != 2'h0)
                        cnt_nxt[ev_set] = cnt_r[ev_set] - 2'h1;
                EV_RX_READ:
                begin
                    if (cnt_r[ev_set] != 2'h0)
                        cnt_nxt[ev_set] = cnt_r[ev_set] - 2'h1;
                    clr_nxt.valid = 1'b1;
                    clr_nxt.sel = ev.sel;
                end
            endcase
        end
        // Forced flush empties every buffer of the set, OUT sets only
        if (wr_ctl && hwdata[CTL_FLUSH] && !idx_r.dir)
        begin
            cnt_nxt[cur] = 2'h0;
            clr_nxt.valid = 1'b1;
            clr_nxt.sel = idx_r;
        end
        if (usb_bus_reset)
        begin
            cnt_nxt = '{default: '0};
            clr_nxt = '0;
        end
    end

    // Token answers and byte count reload
    always_comb
    begin
        logic [SW-1:0] t;
        uecs_sel_s ts;
        t = '0;
        ts = '0;
        ts.setup = (tok.pid == PID_SETUP);
        ts.ep = ts.setup ? 4'h0 : tok.ep;
        ts.dir = (tok.pid == PID_IN);
        t = set_of(ts);
        resp_nxt = '0;
        resp_nxt.valid = tok.valid;
        resp_nxt.transactions_per_microframe = nt_r[t];
        resp_nxt.max_size = size_r[t];
        if (ts.ep == 4'h0)
        begin
            resp_nxt.max_size = ts.setup ? SETUP_SIZE : EP0_MAX_SIZE;
            resp_nxt.transactions_per_microframe = '0;
        end
        if (ts.setup)
            resp_nxt.hs = HS_ACK;
        else if (stall_r[t])
            resp_nxt.hs = HS_STALL;
        else if (ts.ep == 4'h0 && stat_r)
            resp_nxt.hs = ts.dir ? HS_ZLP : HS_ACK;
        else if (ts.ep == 4'h0 && !data_r)
            resp_nxt.hs = HS_NAK;
        else if (ts.dir)
            resp_nxt.hs = (cnt_r[t] != 2'h0) ? HS_DATA : HS_NAK;
        else
            resp_nxt.hs = (cnt_r[t] != cap_of(dbl_buf[t])) ? HS_ACK : HS_NAK;
        load_nxt = '0;
        if (wr_sz && !cur_ep0)
        begin
            load_nxt.valid = 1'b1;
            load_nxt.sel = idx_r;
            load_nxt.val = hwdata[SZ_LSB +: SZ_W];
        end
        if (usb_bus_reset)
        begin
            resp_nxt = '0;
            load_nxt = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ph_valid_r <= 1'b0;
            ph_write_r <= 1'b0;
            ph_addr_r <= 32'h0000_0000;
            idx_r <= EIX_MASTER_RST;
            stall_r <= '0;
            size_r <= '{default: '0};
            nt_r <= '{default: '0};
            stat_r <= 1'b0;
            data_r <= 1'b0;
            cnt_r <= '{default: '0};
            resp_r <= '0;
            load_r <= '0;
            clr_r <= '0;
        end
        else
        begin
            ph_valid_r <= ph_valid_nxt;
            ph_write_r <= ph_write_nxt;
            ph_addr_r <= ph_addr_nxt;
            idx_r <= idx_nxt;
            stall_r <= stall_nxt;
            size_r <= size_nxt;
            nt_r <= nt_nxt;
            stat_r <= stat_nxt;
            data_r <= data_nxt;
            cnt_r <= cnt_nxt;
            resp_r <= resp_nxt;
            load_r <= load_nxt;
            clr_r <= clr_nxt;
        end
    end
endmodule
`default_nettype wire

//--- hdl/uecs_pkg.sv
/*
 * Constants and carrier types for the endpoint control and sizing block.
 * Assumes a single 100 MHz system clock and AHB-Lite register access.
 */
`default_nettype none
package uecs_pkg;
    // Register byte addresses
    localparam logic [31:0] ADDR_MAXSIZE = 32'h8004_1004;
    localparam logic [31:0] ADDR_ECTRL = 32'h8004_1028;
    localparam logic [31:0] ADDR_EIX = 32'h8004_102C;
    // Endpoint control fields
    localparam int CTL_STALL = 0;
    localparam int CTL_STATUS = 1;
    localparam int CTL_DATA = 2;
    localparam int CTL_FLUSH = 4;
    localparam int CTL_FULL = 5;
    // Packet size fields
    localparam int SZ_LSB = 0;
    localparam int SZ_W = 11;
    localparam int NT_LSB = 11;
    localparam int NT_W = 2;
    // Index register width, fixed sizes of control endpoint 0
    localparam int EIX_W = 6;
    localparam logic [SZ_W-1:0] EP0_MAX_SIZE = 11'h040;
    localparam logic [SZ_W-1:0] SETUP_SIZE = 11'h008;
    localparam logic [EIX_W-1:0] EIX_MASTER_RST = 6'h20;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic setup;
        logic [3:0] ep;
        logic dir;
    } uecs_sel_s;

    typedef enum logic [2:0] {
        PID_SETUP = 3'h1,
        PID_IN = 3'h2,
        PID_OUT = 3'h4
    } uecs_pid_e;

    typedef struct packed {
        logic valid;
        uecs_pid_e pid;
        logic [3:0] ep;
    } uecs_tok_s;

    typedef enum logic [1:0] {
        EV_TX_VALID = 2'h0,
        EV_TX_ACKED = 2'h1,
        EV_RX_ACKED = 2'h2,
        EV_RX_READ = 2'h3
    } uecs_evk_e;

    typedef struct packed {
        logic valid;
        uecs_evk_e kind;
        uecs_sel_s sel;
    } uecs_ev_s;

    typedef enum logic [2:0] {
        HS_ACK = 3'h0,
        HS_NAK = 3'h1,
        HS_STALL = 3'h2,
        HS_DATA = 3'h3,
        HS_ZLP = 3'h4
    } uecs_hs_e;

    typedef struct packed {
        logic valid;
        uecs_hs_e hs;
        logic [SZ_W-1:0] max_size;
        logic [NT_W-1:0] transactions_per_microframe;
    } uecs_resp_s;

    typedef struct packed {
        logic valid;
        uecs_sel_s sel;
        logic [SZ_W-1:0] val;
    } uecs_cnt_s;

    typedef struct packed {
        logic valid;
        uecs_sel_s sel;
    } uecs_clr_s;
endpackage
`default_nettype wire

//--- verif/uecs_top_sva.sv
/* Port checker for uecs_top: response timing, pulses, read data.
 * Assumes it is bound to every uecs_top instance. */
`default_nettype none
module uecs_top_sva #(
    parameter int NUM_EP = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic usb_bus_reset,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire uecs_pkg::uecs_tok_s tok,
    input wire uecs_pkg::uecs_ev_s ev,
    input wire uecs_pkg::uecs_resp_s resp,
    input wire uecs_pkg::uecs_cnt_s cnt_load,
    input wire uecs_pkg::uecs_clr_s rx_clear
);
    import uecs_pkg::*;
    logic rd_r;
    logic tok0;
    // Marks a read data phase
    always_ff @(posedge ref_clk or negedge reset_n)
        if (!reset_n)
            rd_r <= 1'b0;
        else
            rd_r <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    assign tok0 = tok.valid && tok.ep == 4'h0 && tok.pid != PID_SETUP;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n || usb_bus_reset);
    property p_lat; tok.valid |=> resp.valid; endproperty
    property p_only; !tok.valid |=> !resp.valid; endproperty
    property p_setup;
        tok.valid && tok.pid == PID_SETUP
            |=> resp.hs == HS_ACK && resp.max_size == SETUP_SIZE;
    endproperty
    property p_ep0;
        tok0 |=> resp.max_size == EP0_MAX_SIZE && resp.transactions_per_microframe == 2'h0;
    endproperty
    property p_rdout;
        ev.valid && ev.kind == EV_RX_READ
            |=> rx_clear.valid && rx_clear.sel == $past(ev.sel);
    endproperty
    property p_clr; rx_clear.valid |-> !rx_clear.sel.dir; endproperty
    property p_cnt;
        cnt_load.valid |-> !cnt_load.sel.setup && cnt_load.sel.ep != 4'h0;
    endproperty
    property p_idle; !rd_r |-> hrdata == 32'h0; endproperty
    a_lat: assert property (p_lat)
        else $error("late response");
    a_only: assert property (p_only)
        else $error("stray response");
    a_setup: assert property (p_setup)
        else $error("setup answer");
    a_ep0: assert property (p_ep0)
        else $error("ep0 size");
    a_rdout: assert property (p_rdout)
        else $error("no read-out clear");
    a_clr: assert property (p_clr)
        else $error("clear on IN set");
    a_cnt: assert property (p_cnt)
        else $error("ep0 count reload");
    a_idle: assert property (p_idle)
        else $error("read data outside phase");
    c_stall: cover property (resp.valid && resp.hs == HS_STALL);
    c_zlp: cover property (resp.valid && resp.hs == HS_ZLP);
    c_cnt: cover property (cnt_load.valid);
endmodule
bind uecs_top uecs_top_sva #(.NUM_EP(NUM_EP)) sva_u (.ref_clk, .reset_n,
    .usb_bus_reset, .hsel, .htrans, .hwrite, .hready, .hrdata, .tok, .ev,
    .resp, .cnt_load, .rx_clear);
`default_nettype wire

//--- verif/uecs_usb_host.sv
/* Host model: issues tokens and keeps the last handshake.
 * Assumes one token per send pulse. */
`default_nettype none
module uecs_usb_host (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic send,
    input wire uecs_pkg::uecs_pid_e pid,
    input wire logic [3:0] ep,
    output uecs_pkg::uecs_tok_s tok,
    input wire uecs_pkg::uecs_resp_s resp,
    output uecs_pkg::uecs_resp_s seen,
    output var int n_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    import uecs_pkg::*;
    always_ff @(posedge ref_clk or negedge reset_n)
        if (!reset_n)
        begin
            tok <= '0;
            seen <= '0;
            n_seen <= 0;
        end
        else
        begin
            // Idle token lines carry a scrambled endpoint
            tok <= send ? {1'b1, pid, ep} : {1'b0, pid, ~ep};
            if (resp.valid)
            begin
                seen <= resp;
                n_seen <= n_seen + 1;
            end
        end
endmodule
`default_nettype wire

//--- verif/tb_usb_endpoint_control_sizing.sv
/* Testbench for uecs_top with AHB-Lite master and host model.
 * Assumes the checker binds itself to uecs_top. */
`default_nettype none
module tb_usb_endpoint_control_sizing;
    timeunit 1ns;
    timeprecision 1ns;
    import uecs_pkg::*;
    logic ref_clk, reset_n, usb_bus_reset, hsel, hwrite, send;
    logic hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [16:0] dbl_buf;
    logic [10:0] sz, cl_val;
    logic [3:0] k, j, tep;
    uecs_pid_e pid;
    uecs_tok_s tok;
    uecs_ev_s ev;
    uecs_resp_s resp, seen;
    uecs_cnt_s cnt_load;
    uecs_clr_s rx_clear;
    int n_seen, n_mismatch, check_count;
    uecs_top #(.NUM_EP(8)) dut_u (.ref_clk, .reset_n, .usb_bus_reset,
        .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .tok, .ev,
        .dbl_buf, .resp, .cnt_load, .rx_clear);
    uecs_usb_host host_u (.ref_clk, .reset_n, .send, .pid, .ep(tep),
        .tok, .resp, .seen, .n_seen);
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
        if (cnt_load.valid === 1'b1)
            cl_val <= cnt_load.val;
    task automatic check(input string nm, input logic [31:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask
    task automatic rc(input string nm, input logic [31:0] a, exp);
        bus(1'b0, a, 32'h0);
        check(nm, q, exp);
    endtask
    task automatic evt(input uecs_evk_e e, input logic [3:0] n, logic d);
        @(posedge ref_clk);
        ev <= {1'b1, e, 1'b0, n, d};
        @(posedge ref_clk);
        ev <= '0;
    endtask
    task automatic tk(input uecs_pid_e p, input logic [3:0] n, uecs_hs_e x);
        int n0;
        n0 = n_seen;
        @(posedge ref_clk);
        send <= 1'b1;
        pid <= p;
        tep <= n;
        @(posedge ref_clk);
        send <= 1'b0;
        repeat (10) @(posedge ref_clk) if (n_seen != n0) break;
        check("resp count", n_seen, n0 + 1);
        check("handshake", seen.hs, x);
    endtask
    function automatic logic [31:0] ix(input logic [3:0] n, logic d);
        return {27'h0, n, d};
    endfunction
    function automatic logic [31:0] szw(input int nt, logic [10:0] s);
        return {19'h0, nt[1:0], s};
    endfunction
    // Whole run needs a few hundred cycles
    initial
    begin
        #100000;
        n_mismatch++;
        stop_test();
    end
    initial
    begin
        n_mismatch = 0;
        check_count = 0;
        reset_n = 1'b0;
        usb_bus_reset = 1'b0;
        {hsel, hwrite, send, haddr, hwdata, htrans, tep, ev} = '0;
        hsize = 3'h2;
        pid = PID_IN;
        void'($urandom(32'h7ec5));
        k = 4'($urandom_range(7, 1));
        j = k % 4'h7 + 4'h1;
        dbl_buf = 17'h1FFFF;
        dbl_buf[2 * j + 1] = 1'b0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        rc("index", ADDR_EIX, 32'h20);
        rc("ctrl", ADDR_ECTRL, 32'h0);
        rc("size", ADDR_MAXSIZE, 32'h0);
        rc("unmapped", 32'h8004_1000, 32'h0);
        bus(1'b1, ADDR_EIX, ix(k, 1'b0));
        for (int nt = 0; nt < 3; nt++)
        begin
            sz = 11'($urandom_range(2047, 1));
            bus(1'b1, ADDR_MAXSIZE, szw(nt, sz));
            repeat (2) @(posedge ref_clk);
            check("reload", cl_val, sz);
            rc("size", ADDR_MAXSIZE, szw(nt, sz));
            tk(PID_OUT, k, HS_ACK);
            check("max", seen.max_size, sz);
            check("transactions_per_microframe", seen.transactions_per_microframe, 32'(nt));
        end
        bus(1'b1, ADDR_ECTRL, 32'h1);
        tk(PID_OUT, k, HS_STALL);
        rc("stall", ADDR_ECTRL, 32'h1);
        bus(1'b1, ADDR_ECTRL, 32'h0);
        evt(EV_RX_ACKED, k, 1'b0);
        rc("out one", ADDR_ECTRL, 32'h20);
        evt(EV_RX_ACKED, k, 1'b0);
        tk(PID_OUT, k, HS_NAK);
        evt(EV_RX_READ, k, 1'b0);
        rc("out half", ADDR_ECTRL, 32'h20);
        evt(EV_RX_READ, k, 1'b0);
        rc("read out", ADDR_ECTRL, 32'h0);
        evt(EV_RX_ACKED, k, 1'b0);
        bus(1'b1, ADDR_ECTRL, 32'h10);
        rc("flush", ADDR_ECTRL, 32'h0);
        bus(1'b1, ADDR_EIX, ix(k, 1'b1));
        evt(EV_TX_VALID, k, 1'b1);
        rc("in half", ADDR_ECTRL, 32'h0);
        tk(PID_IN, k, HS_DATA);
        evt(EV_TX_VALID, k, 1'b1);
        rc("in both", ADDR_ECTRL, 32'h20);
        evt(EV_TX_ACKED, k, 1'b1);
        rc("in acked", ADDR_ECTRL, 32'h0);
        bus(1'b1, ADDR_EIX, ix(j, 1'b1));
        evt(EV_TX_VALID, j, 1'b1);
        rc("in single", ADDR_ECTRL, 32'h20);
        bus(1'b1, ADDR_EIX, 32'h0);
        tk(PID_IN, 4'h0, HS_NAK);
        tk(PID_OUT, 4'h0, HS_NAK);
        bus(1'b1, ADDR_ECTRL, 32'h2);
        rc("status", ADDR_ECTRL, 32'h2);
        tk(PID_IN, 4'h0, HS_ZLP);
        check("ep0 max", seen.max_size, 32'h40);
        tk(PID_OUT, 4'h0, HS_ACK);
        tk(PID_SETUP, 4'h0, HS_ACK);
        check("setup max", seen.max_size, 32'h8);
        rc("setup clr", ADDR_ECTRL, 32'h0);
        bus(1'b1, ADDR_ECTRL, 32'h4);
        tk(PID_OUT, 4'h0, HS_ACK);
        bus(1'b1, ADDR_ECTRL, 32'h2);
        evt(EV_RX_ACKED, 4'h0, 1'b0);
        tk(PID_IN, 4'h0, HS_NAK);
        bus(1'b1, ADDR_ECTRL, 32'h2);
        @(posedge ref_clk);
        usb_bus_reset <= 1'b1;
        @(posedge ref_clk);
        usb_bus_reset <= 1'b0;
        tk(PID_IN, 4'h0, HS_NAK);
        rc("bus index", ADDR_EIX, 32'h0);
        rc("bus ctrl", ADDR_ECTRL, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
